// >>> logic/cap_touch_regs.vh
// Register map, field positions and reset values of the capacitive touch status readout.
// Assumes an APB master with 32-bit data and byte addresses.
// Summary of operation
// - Delta bytes are signed eight-bit values that saturate at -128 and 127.
// - Electrodes 0 to 3 each report a delta against their baseline.
// - Motion status bit 7 is set while movement is being detected.
// - Motion bit 6 gives direction, 1 incrementing, held after movement stops.
// - Motion bits 3-0 count positions advanced since the previous update.
// - Position status bit 7 shows a touch on the control.
// - Position bit 6 flags non-adjacent electrodes touched together.
// - Position bits 4-0 give the absolute actuated position.
// - Adjacent electrode pairs report intermediate positions, so resolution exceeds electrode count.
// - Key events for electrodes 0 to 3 are queued only in keypad mode.
// - Queue entry bit 7 is 1 for a release, 0 for a press.
// - Queue entry bits 1-0 give the key index; bits 6-2 read zero.
// - Status registers other than interrupt status are read only; writes get an error response.
// - Keypad mode is control type field equal to both ones.
`ifndef CAP_TOUCH_REGS_VH
`define CAP_TOUCH_REGS_VH
`define ADDR_DELTA0      8'h00
`define ADDR_DELTA3      8'h0c
`define ADDR_MOTION      8'h10
`define ADDR_POSITION    8'h14
`define ADDR_KEY_QUEUE   8'h18
`define ADDR_CONFIG      8'h1c
`define ADDR_IRQ_STATUS  8'h20
`define ADDR_IRQ_MASK    8'h24
`define CFG_TYPE_HI      6
`define CFG_TYPE_LO      5
`define CFG_RESET        8'h00
`define TYPE_DISABLED    2'h0
`define TYPE_ROTARY      2'h1
`define TYPE_SLIDER      2'h2
`define TYPE_KEYPAD      2'h3
`define MOT_ACTIVE_BIT   7
`define MOT_DIR_BIT      6
`define POS_TOUCH_BIT    7
`define POS_INVALID_BIT  6
`define KEY_RELEASE_BIT  7
`define IRQ_KEY_BIT      0
`define IRQ_MOTION_BIT   1
`define IRQ_INVALID_BIT  2
`define IRQ_W            3
`define DELTA_MAX        8'h7f
`define DELTA_MIN        8'h80
`endif

// >>> logic/cap_touch_status_readout.v
// Capacitive touch status readout: delta, slider/rotary status and keypad event queue over APB.
// Assumes the measurement logic on pclk supplies raw deltas, touch bits and an update strobe.
`timescale 1ns/1ps
`include "cap_touch_regs.vh"
// Register map, one byte per 32-bit word in bits 7:0:
//   0x00-0x0c  delta of electrodes 0 to 3, read only
//              signed, saturating at -128 and 127
//   0x10       motion status, read only
//              bit 7    movement seen on the last update
//              bit 6    direction, 1 incrementing, held while still
//              bits 3-0 positions advanced since the previous update
//   0x14       position status, read only
//              bit 7    control touched
//              bit 6    invalid electrode combination
//              bits 4-0 last valid absolute position
//   0x18       key event queue, read only, a read pops the oldest entry
//              bit 7    1 for a release, 0 for a press
//              bits 1-0 electrode index, bits 6-2 read zero
//   0x1c       configuration, bits 6-5 electrode control type
//              0 off, 1 rotary, 2 slider, 3 keypad
//   0x20       interrupt status, write one to clear
//   0x24       interrupt mask, same layout as the status
//              bit 0    key event queued
//              bit 1    movement detected
//              bit 2    invalid combination began
//
// Bus behaviour:
//   pready is tied high, every transfer ends in its first access cycle.
//   Read data is latched in the setup cycle and holds until the next setup.
//   Writes to read-only words and any unmapped access end with pslverr.
//   A refused write changes nothing.
//   Reading an empty queue returns zero and is not an error.
//
// Sensor side:
//   raw_delta, electrode_touched and sample_update come from logic on pclk,
//   so they are used without synchronisers.
//   Delta, motion and position status change only on the cycle after a sample_update pulse.
//   Keypad events are taken one per cycle, lowest changed electrode first.
//   A full queue stalls new events rather than dropping them; the host must
//   drain it to see later key changes.
//   Changing the control type does not flush the queue.
//   In keypad mode the slider and rotary status read as not touched.
//   Three or more touched electrodes always count as invalid on a slider or rotary.
module cap_touch_status_readout #(
  parameter RAW_W   = 16,
  parameter QDEPTH  = 8,
  parameter QAW     = 3
) (
  input  wire                 pclk,
  input  wire                 presetn,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [7:0]           paddr,
  input  wire [31:0]          pwdata,
  output wire                 pready,
  output reg  [31:0]          prdata,
  output wire                 pslverr,
  input  wire [4*RAW_W-1:0]   raw_delta,
  input  wire [3:0]           electrode_touched,
  input  wire                 sample_update,
  output wire [1:0]           electrode_control_type,
  output wire                 irq
);

  reg  [7:0]        config_reg;
  reg  [31:0]       electrode_delta_value;
  reg               motion_active;
  reg               motion_direction;
  reg  [3:0]        steps_advanced;
  reg               control_touched;
  reg               invalid_combination;
  reg  [4:0]        position;
  reg  [4:0]        prev_position;
  reg               prev_valid;
  reg  [3:0]        reported_keys;
  reg  [7:0]        queue_mem [0:QDEPTH-1];
  reg  [QAW-1:0]    wr_ptr;
  reg  [QAW-1:0]    rd_ptr;
  reg  [QAW:0]      q_count;
  reg  [`IRQ_W-1:0] irq_status;
  reg  [`IRQ_W-1:0] irq_mask;

  wire setup    = psel & ~penable;
  wire access   = psel & penable;
  wire is_delta = (paddr >= `ADDR_DELTA0) && (paddr <= `ADDR_DELTA3) && (paddr[1:0] == 2'h0);
  wire is_ro    = is_delta || (paddr == `ADDR_MOTION) || (paddr == `ADDR_POSITION) || (paddr == `ADDR_KEY_QUEUE);
  wire is_rw    = (paddr == `ADDR_CONFIG) || (paddr == `ADDR_IRQ_STATUS) || (paddr == `ADDR_IRQ_MASK);
  wire wr_ok    = access & pwrite & is_rw;

  // Per-register hits, shared by the write and pop paths
  wire hit_queue    = (paddr == `ADDR_KEY_QUEUE);
  wire hit_config   = (paddr == `ADDR_CONFIG);
  wire hit_irq_stat = (paddr == `ADDR_IRQ_STATUS);
  wire hit_irq_mask = (paddr == `ADDR_IRQ_MASK);
  wire wr_config    = wr_ok & hit_config;
  wire wr_irq_stat  = wr_ok & hit_irq_stat;
  wire wr_irq_mask  = wr_ok & hit_irq_mask;

  assign pready  = 1'b1;
  // Writes to status registers other than interrupt status and any unmapped access end with an error
  wire write_refused = access & pwrite & ~is_rw;
  wire addr_unmapped = access & ~is_ro & ~is_rw;
  assign pslverr = write_refused | addr_unmapped;

  assign electrode_control_type = config_reg[`CFG_TYPE_HI:`CFG_TYPE_LO];
  wire keypad_mode = (electrode_control_type == `TYPE_KEYPAD);
  wire rotary_mode = (electrode_control_type == `TYPE_ROTARY);
  wire sr_mode     = rotary_mode || (electrode_control_type == `TYPE_SLIDER);

  // Delta saturation, one lane per electrode
  wire [31:0] next_delta;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_delta
      wire signed [RAW_W-1:0] raw = raw_delta[g*RAW_W +: RAW_W];
      assign next_delta[g*8 +: 8] = (raw > $signed(16'sd127))  ? `DELTA_MAX :
                                    (raw < -$signed(16'sd128)) ? `DELTA_MIN :
                                    raw[7:0];
    end
  endgenerate

  // Position decode: single electrode i gives 2i, adjacent pair i,i+1 gives 2i+1
  reg       next_invalid;
  reg [4:0] next_position;
  reg [2:0] n_touched;
  integer   i;
  always @* begin
    next_invalid  = 1'b0;
    next_position = 5'h00;
    n_touched     = 3'h0;
    for (i = 0; i < 4; i = i + 1) begin
      if (electrode_touched[i])
        n_touched = n_touched + 3'h1;
    end
    case (electrode_touched)
      4'b0001: next_position = 5'h00;
      4'b0011: next_position = 5'h01;
      4'b0010: next_position = 5'h02;
      4'b0110: next_position = 5'h03;
      4'b0100: next_position = 5'h04;
      4'b1100: next_position = 5'h05;
      4'b1000: next_position = 5'h06;
      4'b1001: begin
        // Electrodes 3 and 0 only neighbour each other on a closed ring
        if (rotary_mode)
          next_position = 5'h07;
        else
          next_invalid = 1'b1;
      end
      4'b0000: next_position = 5'h00;
      default: next_invalid = 1'b1;
    endcase
    if (n_touched > 3'h2)
      next_invalid = 1'b1;
  end

  // Signed step between updates, folded into half a turn on the rotary
  // A jump of more than half a turn is taken as the shorter way round
  wire signed [5:0] raw_step = $signed({1'b0, next_position}) - $signed({1'b0, prev_position});
  reg  signed [5:0] step;
  reg         [5:0] step_mag;
  always @* begin
    step = raw_step;
    if (rotary_mode && (raw_step > 6'sd4))
      step = raw_step - 6'sd8;
    else if (rotary_mode && (raw_step < -6'sd4))
      step = raw_step + 6'sd8;
    step_mag = step[5] ? (6'h00 - step) : step;
  end

  wire cur_valid = sr_mode & (|electrode_touched) & ~next_invalid;
  wire moving    = sample_update & cur_valid & prev_valid & (step != 6'sd0);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      electrode_delta_value <= 32'h00000000;
      motion_active         <= 1'b0;
      motion_direction      <= 1'b0;
      steps_advanced        <= 4'h0;
      control_touched       <= 1'b0;
      invalid_combination   <= 1'b0;
      position              <= 5'h00;
      prev_position         <= 5'h00;
      prev_valid            <= 1'b0;
    end else if (sample_update) begin
      electrode_delta_value <= next_delta;
      control_touched       <= sr_mode & (|electrode_touched);
      invalid_combination   <= sr_mode & next_invalid;
      motion_active         <= moving;
      // Step count saturates at the field width on very fast swipes
      steps_advanced        <= moving ? ((step_mag > 6'h0f) ? 4'hf : step_mag[3:0]) : 4'h0;
      if (moving)
        motion_direction <= ~step[5];
      if (cur_valid) begin
        position      <= next_position;
        prev_position <= next_position;
      end
      prev_valid <= cur_valid;
    end
  end

  // Key event queue: one event per cycle, lowest changed key first
  reg       change_found;
  reg [1:0] change_key;
  always @* begin
    change_found = 1'b0;
    change_key   = 2'h0;
    for (i = 3; i >= 0; i = i - 1) begin
      if (electrode_touched[i] != reported_keys[i]) begin
        change_found = 1'b1;
        change_key   = i[1:0];
      end
    end
  end

  wire q_full  = (q_count == QDEPTH[QAW:0]);
  wire q_empty = (q_count == {(QAW+1){1'b0}});
  // A full queue holds the change pending, so no event is lost
  wire push    = keypad_mode & change_found & ~q_full;
  // Depth must be a power of two: the pointers wrap by overflow
  wire pop     = access & ~pwrite & hit_queue & ~q_empty;
  wire [7:0] event_entry = {~electrode_touched[change_key], 5'h00, change_key};

  always @(posedge pclk) begin
    if (push)
      queue_mem[wr_ptr] <= event_entry;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reported_keys <= 4'h0;
      wr_ptr        <= {QAW{1'b0}};
      rd_ptr        <= {QAW{1'b0}};
      q_count       <= {(QAW+1){1'b0}};
    end else begin
      if (!keypad_mode)
        reported_keys <= electrode_touched;
      else if (push)
        reported_keys[change_key] <= electrode_touched[change_key];
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        q_count <= q_count + 1'b1;
      else if (pop && !push)
        q_count <= q_count - 1'b1;
    end
  end

  // Interrupt flags: hardware set wins over a write-one clear in the same cycle
  // Invalid flag fires only on the update that begins an invalid combination
  wire irq_set_invalid = sample_update & sr_mode & next_invalid & ~invalid_combination;
  wire irq_set_motion  = moving;
  wire irq_set_key     = push;
  wire [`IRQ_W-1:0] irq_set = {irq_set_invalid, irq_set_motion, irq_set_key};
  wire [`IRQ_W-1:0] irq_clr = wr_irq_stat ? pwdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
  assign irq = |(irq_status & irq_mask);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= `CFG_RESET;
      irq_status <= {`IRQ_W{1'b0}};
      irq_mask   <= {`IRQ_W{1'b0}};
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      if (wr_config)
        config_reg <= {1'b0, pwdata[`CFG_TYPE_HI:`CFG_TYPE_LO], 5'h00};
      if (wr_irq_mask)
        irq_mask <= pwdata[`IRQ_W-1:0];
    end
  end

  // Read data is captured in the setup cycle so the zero-wait access phase sees a flop
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (is_delta)
      rd_byte = electrode_delta_value[paddr[3:2]*8 +: 8];
    else begin
      case (paddr)
        `ADDR_MOTION:     rd_byte = {motion_active, motion_direction, 2'h0, steps_advanced};
        `ADDR_POSITION:   rd_byte = {control_touched, invalid_combination, 1'b0, position};
        `ADDR_KEY_QUEUE:  rd_byte = q_empty ? 8'h00 : queue_mem[rd_ptr];
        `ADDR_CONFIG:     rd_byte = config_reg;
        `ADDR_IRQ_STATUS: rd_byte = {5'h00, irq_status};
        `ADDR_IRQ_MASK:   rd_byte = {5'h00, irq_mask};
        default:          rd_byte = 8'h00;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      // Upper bytes are always zero: each register is one byte wide
      prdata <= {24'h000000, rd_byte};
    end
  end

endmodule // cap_touch_status_readout

// >>> tb/cap_touch_chk.sv
// Port-level checks for the touch status readout: APB answers and register formats.
// Assumes it is bound into the readout top module.
`timescale 1ns/1ps
module cap_touch_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [1:0]  electrode_control_type
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel & penable;
  wire logic rd_acc = acc & ~pwrite;
  property p_wr_ro; acc && pwrite && paddr < 8'h1c |-> pslverr; endproperty
  a_wr_ro: assert property (p_wr_ro) else $error("status write not refused");
  property p_err_idle; !acc |-> !pslverr; endproperty
  a_err_idle: assert property (p_err_idle) else $error("error outside access");
  property p_unmap; rd_acc && paddr > 8'h24 |-> pslverr && prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read answer wrong");
  property p_rd_ok; rd_acc && paddr <= 8'h24 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_rd_ok: assert property (p_rd_ok) else $error("mapped read refused");
  property p_type; !$stable(electrode_control_type) |-> $past(acc && pwrite && paddr == 8'h1c); endproperty
  a_type: assert property (p_type) else $error("type changed without write");
  property p_key; rd_acc && paddr == 8'h18 |-> prdata[31:8] == 24'h0 && prdata[6:2] == 5'h0; endproperty
  a_key: assert property (p_key) else $error("queue entry format");
  property p_mot; rd_acc && paddr == 8'h10 && !prdata[7] |-> prdata[5:0] == 6'h0; endproperty
  a_mot: assert property (p_mot) else $error("steps without motion");
  property p_pos; rd_acc && paddr == 8'h14 |-> prdata[5] == 1'b0; endproperty
  a_pos: assert property (p_pos) else $error("position reserved bit set");
  property p_hold; acc |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved in access");
endmodule // cap_touch_chk

bind cap_touch_status_readout cap_touch_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .electrode_control_type(electrode_control_type));

// >>> tb/touch_sensor_model.sv
// Stand-in for the measurement logic: raw deltas, touch levels and the update strobe.
// Assumes the bench calls apply between its own bus transfers, on pclk.
`timescale 1ns/1ps
module touch_sensor_model (
  input  wire logic        pclk,
  output logic      [63:0] raw_delta,
  output logic      [3:0]  electrode_touched,
  output logic             sample_update
);
  initial begin
    raw_delta = 64'h0;
    electrode_touched = 4'h0;
    sample_update = 1'b0;
  end
  // One-cycle strobe, then one spare edge so the latched status is settled
  task automatic apply(input logic [63:0] d, input logic [3:0] t);
    @(posedge pclk);
    raw_delta <= d;
    electrode_touched <= t;
    sample_update <= 1'b1;
    @(posedge pclk);
    sample_update <= 1'b0;
    @(posedge pclk);
  endtask
endmodule // touch_sensor_model

// >>> tb/tb.sv
// Self-checking bench for the touch status readout over APB.
// Assumes zero-wait APB answers and status visible one cycle after an update.
`timescale 1ns/1ps
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] raw_delta;
  logic [3:0]  electrode_touched;
  logic        sample_update;
  logic [1:0]  electrode_control_type;
  int          failures, total_checks;
  cap_touch_status_readout dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .raw_delta(raw_delta), .electrode_touched(electrode_touched),
    .sample_update(sample_update), .electrode_control_type(electrode_control_type), .irq(irq));
  touch_sensor_model sen_u (.pclk(pclk), .raw_delta(raw_delta), .electrode_touched(electrode_touched),
    .sample_update(sample_update));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      end_of_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
    xfer(a, 1'b0, 32'h0);
    chk(rd, e);
    chk(err, ee);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    xfer(a, 1'b1, d);
    chk(err, ee);
  endtask
  task t_regs;
    rdc(8'h28, 32'h0, 1'b1);
    for (int a = 0; a <= 24; a += 4) wr(a[7:0], 32'hff, 1'b1);
    rdc(8'h00, 32'h0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(8'h1c, i << 5, 1'b0);
      rdc(8'h1c, i << 5, 1'b0);
      chk(electrode_control_type, i);
    end
    $display("test regs done");
  endtask
  task t_delta;
    sen_u.apply(64'hfffb_0005_fed4_012c, 4'h0);
    rdc(8'h00, 32'h7f, 1'b0);
    rdc(8'h04, 32'h80, 1'b0);
    rdc(8'h08, 32'h05, 1'b0);
    rdc(8'h0c, 32'hfb, 1'b0);
    $display("test delta done");
  endtask
  task t_keypad;
    wr(8'h1c, 32'h60, 1'b0);
    wr(8'h24, 32'h1, 1'b0);
    sen_u.apply(64'h0, 4'b1001);
    chk(irq, 1'b1);
    rdc(8'h18, 32'h00, 1'b0);
    rdc(8'h18, 32'h03, 1'b0);
    sen_u.apply(64'h0, 4'b0000);
    rdc(8'h18, 32'h80, 1'b0);
    rdc(8'h18, 32'h83, 1'b0);
    rdc(8'h18, 32'h00, 1'b0);
    wr(8'h20, 32'h1, 1'b0);
    @(posedge pclk);
    chk(irq, 1'b0);
    wr(8'h1c, 32'h40, 1'b0);
    sen_u.apply(64'h0, 4'b0010);
    rdc(8'h18, 32'h00, 1'b0);
    $display("test keypad done");
  endtask
  task t_slider;
    sen_u.apply(64'h0, 4'b0001);
    rdc(8'h10, 32'h82, 1'b0);
    sen_u.apply(64'h0, 4'b0001);
    rdc(8'h10, 32'h00, 1'b0);
    sen_u.apply(64'h0, 4'b0110);
    rdc(8'h10, 32'hc3, 1'b0);
    rdc(8'h14, 32'h83, 1'b0);
    sen_u.apply(64'h0, 4'b0110);
    rdc(8'h10, 32'h40, 1'b0);
    sen_u.apply(64'h0, 4'b0101);
    rdc(8'h14, 32'hc3, 1'b0);
    sen_u.apply(64'h0, 4'b0000);
    rdc(8'h14, 32'h03, 1'b0);
    $display("test slider done");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    failures = 0;
    total_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_delta;
    t_keypad;
    t_slider;
    end_of_test;
  end
endmodule // tb
